/* File: common/cdcr_pkg.sv */
// shared constants and types of the card and device control register bank
package cdcr_pkg;
	// register offsets in configuration space
	localparam logic [7:0] CDCR_CARD_CTRL_OFS = 8'h91;
	localparam logic [7:0] CDCR_DEV_CTRL_OFS = 8'h92;
	// card control fields
	localparam int CDCR_CC_RING_EN = 7;
	localparam int CDCR_CC_KEEP_HI = 6; // software leaves 6..3 as found
	localparam int CDCR_CC_KEEP_LO = 3;
	localparam int CDCR_CC_AUDIO = 2;
	localparam int CDCR_CC_SPK = 1;
	localparam int CDCR_CC_IFLAG = 0;
	localparam logic [7:0] CDCR_CC_RESET = 8'h00;
	localparam logic [7:0] CDCR_CC_KEEP_MASK = 8'h78;
	// device control fields
	localparam int CDCR_DC_LOCK = 7;
	localparam int CDCR_DC_LV = 6;
	localparam int CDCR_DC_DIAG = 5;
	localparam int CDCR_DC_TEST_HI = 3;
	localparam int CDCR_DC_MODE_LO = 1;
	localparam int CDCR_DC_TEST_LO = 0;
	localparam logic [7:0] CDCR_DC_RESET = 8'h66;
	localparam logic [7:0] CDCR_DC_TEST_MASK = 8'h09;
	// terminal configuration code that carries the card audio pwm
	localparam logic [3:0] CDCR_AUDIO_PWM_CODE = 4'h8;
	// interrupt signalling modes
	typedef enum logic [1:0] {
		CDCR_MODE_PARALLEL = 2'b00,
		CDCR_MODE_RSVD = 2'b01,
		CDCR_MODE_SER_PAR = 2'b10,
		CDCR_MODE_SERIAL = 2'b11
	} cdcr_mode_t;
	// host apb register offsets
	localparam logic [11:0] CDCR_APB_CMD = 12'h000;
	localparam logic [11:0] CDCR_APB_STAT = 12'h004;
	localparam logic [11:0] CDCR_APB_ISTAT = 12'h008;
	localparam logic [11:0] CDCR_APB_IMASK = 12'h00c;
	// command word fields
	localparam int CDCR_CMD_GO = 0;
	localparam int CDCR_CMD_WR = 1;
	localparam int CDCR_CMD_FUNC = 2;
	localparam int CDCR_CMD_ADDR_LO = 8;
	localparam int CDCR_CMD_DATA_LO = 16;
	// host sequencer states
	typedef enum logic [2:0] {
		CDCR_H_IDLE = 3'b000,
		CDCR_H_RD_OLD = 3'b001,
		CDCR_H_WAIT_OLD = 3'b010,
		CDCR_H_ACCESS = 3'b011,
		CDCR_H_WAIT_ACC = 3'b100
	} cdcr_hstate_t;
endpackage

/* File: common/cdcr_cfg_if.sv */
// configuration access link between host controller and register bank
interface cdcr_cfg_if;
	logic req; // one-cycle access request
	logic func; // target function 0 or 1
	logic [7:0] addr; // configuration byte offset
	logic wr; // 1 write, 0 read
	logic [7:0] wdata; // write byte
	logic ack; // one-cycle answer
	logic [7:0] rdata; // read byte, valid with ack
	modport dev (input req, func, addr, wr, wdata, output ack, rdata);
	modport host (output req, func, addr, wr, wdata, input ack, rdata);
endinterface

/* File: hw/cdcr_device.sv */
// card control and device control register bank with its card-side pins
// What this block does
// - ring enable bit gates ring output
// - software preserves card control bits six to three
// - audio route bit drives pwm, function 0 wins
// - speaker enable passes xor of both sockets
// - speaker pin driven only while any enable
// - card interrupt sets flag, write one clears
// - marked bits cleared only by global reset
// - global bits single copy, function 0 only
// - power lock refuses power down in d3
// - force bit reports low voltage capability
// - diagnostic bit read/write, resets to one
// - device control bit four reads zero
// - software writes zero to test bit three
// - mode bits select interrupt signalling, reset serial
// - software writes zero to test bit zero
// - terminal code 1000 carries card audio pwm
//
// Added by the designer: register access over APB.
module cdcr_device
	import cdcr_pkg::*;
(
	input wire logic pclk, // bus clock
	input wire logic presetn, // ordinary reset, async low
	input wire logic global_reset_n, // global reset input, async low
	cdcr_cfg_if.dev cfg, // configuration access
	input wire logic ring_in, // ring event from the card pin
	input wire logic [1:0] card_irq_in, // functional interrupt per socket
	input wire logic [1:0] card_speaker_input, // speaker per socket
	input wire logic [1:0] card_audio_signal, // card audio per function
	input wire logic [3:0] multipurpose_terminal_sel, // multipurpose terminal configuration
	input wire logic [1:0] d3_state, // function in d3
	input wire logic [1:0] power_down_req, // software socket power down
	output logic ring_indicate_output, // gated ring
	output logic speaker_output_pin, // speaker data
	output logic speaker_output_pin_oe, // speaker pin drive enable
	output logic card_audio_pwm_output, // routed card audio
	output logic multipurpose_terminal, // terminal level
	output logic [1:0] power_down_grant, // power down allowed per socket
	output logic low_voltage_capable, // reported capability
	output cdcr_pkg::cdcr_mode_t interrupt_signal_mode, // signalling mode
	output logic [1:0] diagnostic_io_bit, // diagnostic bit per function
	output logic [1:0] card_interrupt_flag // flag per socket
);
	import cdcr_pkg::*;

	// pin synchroniser: stage one is read only by stage two
	logic [6:0] sync_a; // first stage
	logic [6:0] sync_b; // second stage, safe to use
	logic ring_s; // synced ring
	logic [1:0] irq_s; // synced interrupts
	logic [1:0] spk_s; // synced speaker
	logic [1:0] aud_s; // synced audio

	// card control storage
	logic ring_en; // shared copy
	logic [1:0] audio_route; // per function
	logic [1:0] spk_en; // per function
	logic [1:0] iflag; // per socket
	logic [1:0] keep_bits [2]; // bits 6..5 per function, ordinary reset
	// device control storage
	logic [1:0] pwr_lock; // per function
	logic [1:0] diag; // per function
	logic lv_force; // shared
	logic test_hi; // shared test bit 3
	logic test_lo; // shared test bit 0
	cdcr_mode_t mode; // shared

	// decoded accesses
	logic wr_cc; // write to card control
	logic wr_dc; // write to device control
	logic fsel; // function addressed
	logic gfn; // write may touch global bits
	logic [7:0] next_rdata; // read mux

	assign ring_s = sync_b[6];
	assign irq_s = sync_b[5:4];
	assign spk_s = sync_b[3:2];
	assign aud_s = sync_b[1:0];
	assign fsel = cfg.func;
	assign wr_cc = cfg.req && cfg.wr && (cfg.addr == CDCR_CARD_CTRL_OFS);
	assign wr_dc = cfg.req && cfg.wr && (cfg.addr == CDCR_DEV_CTRL_OFS);
	// function 1 writes cannot alter the shared copy
	assign gfn = !cfg.func;

	// two flip-flops for every pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_a <= 7'h00;
			sync_b <= 7'h00;
		end else begin
			sync_a <= {ring_in, card_irq_in, card_speaker_input, card_audio_signal};
			sync_b <= sync_a;
		end
	end

	// shared bits live on the global reset only
	always_ff @(posedge pclk or negedge global_reset_n) begin
		if (!global_reset_n) begin
			ring_en <= CDCR_CC_RESET[CDCR_CC_RING_EN];
			lv_force <= CDCR_DC_RESET[CDCR_DC_LV];
			test_hi <= CDCR_DC_RESET[CDCR_DC_TEST_HI];
			test_lo <= CDCR_DC_RESET[CDCR_DC_TEST_LO];
			mode <= cdcr_mode_t'(CDCR_DC_RESET[CDCR_DC_MODE_LO +: 2]);
		end else begin
			if (wr_cc && gfn) begin
				ring_en <= cfg.wdata[CDCR_CC_RING_EN];
			end
			if (wr_dc && gfn) begin
				lv_force <= cfg.wdata[CDCR_DC_LV];
				test_hi <= cfg.wdata[CDCR_DC_TEST_HI];
				test_lo <= cfg.wdata[CDCR_DC_TEST_LO];
				mode <= cdcr_mode_t'(cfg.wdata[CDCR_DC_MODE_LO +: 2]);
			end
		end
	end

	// per-function bits, also global reset only
	always_ff @(posedge pclk or negedge global_reset_n) begin
		if (!global_reset_n) begin
			audio_route <= {2{CDCR_CC_RESET[CDCR_CC_AUDIO]}};
			spk_en <= {2{CDCR_CC_RESET[CDCR_CC_SPK]}};
			pwr_lock <= {2{CDCR_DC_RESET[CDCR_DC_LOCK]}};
			diag <= {2{CDCR_DC_RESET[CDCR_DC_DIAG]}};
		end else begin
			if (wr_cc) begin
				audio_route[fsel] <= cfg.wdata[CDCR_CC_AUDIO];
				spk_en[fsel] <= cfg.wdata[CDCR_CC_SPK];
			end
			if (wr_dc) begin
				pwr_lock[fsel] <= cfg.wdata[CDCR_DC_LOCK];
				diag[fsel] <= cfg.wdata[CDCR_DC_DIAG];
			end
		end
	end

	// interrupt flag per socket; a new event outranks the clearing write
	always_ff @(posedge pclk or negedge global_reset_n) begin
		if (!global_reset_n) begin
			iflag <= {2{CDCR_CC_RESET[CDCR_CC_IFLAG]}};
		end else begin
			for (int s = 0; s < 2; s++) begin
				if (irq_s[s]) begin
					iflag[s] <= 1'b1;
				end else if (wr_cc && (fsel == s[0]) && cfg.wdata[CDCR_CC_IFLAG]) begin
					iflag[s] <= 1'b0;
				end
			end
		end
	end

	// reserved read/write bits 6..5 follow the ordinary reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			keep_bits[0] <= CDCR_CC_RESET[CDCR_CC_KEEP_HI -: 2];
			keep_bits[1] <= CDCR_CC_RESET[CDCR_CC_KEEP_HI -: 2];
		end else if (wr_cc) begin
			keep_bits[fsel] <= cfg.wdata[CDCR_CC_KEEP_HI -: 2];
		end
	end

	// read mux; bits 4..3 of card control and bit 4 of device control read zero
	always_comb begin
		next_rdata = 8'h00;
		if (cfg.addr == CDCR_CARD_CTRL_OFS) begin
			next_rdata[CDCR_CC_RING_EN] = ring_en;
			next_rdata[CDCR_CC_KEEP_HI -: 2] = keep_bits[fsel];
			next_rdata[CDCR_CC_AUDIO] = audio_route[fsel];
			next_rdata[CDCR_CC_SPK] = spk_en[fsel];
			next_rdata[CDCR_CC_IFLAG] = iflag[fsel];
		end else if (cfg.addr == CDCR_DEV_CTRL_OFS) begin
			next_rdata[CDCR_DC_LOCK] = pwr_lock[fsel];
			next_rdata[CDCR_DC_LV] = lv_force;
			next_rdata[CDCR_DC_DIAG] = diag[fsel];
			next_rdata[CDCR_DC_TEST_HI] = test_hi;
			next_rdata[CDCR_DC_MODE_LO +: 2] = mode;
			next_rdata[CDCR_DC_TEST_LO] = test_lo;
		end else begin
			next_rdata = 8'h00; // unmapped offsets read zero
		end
	end

	// answer one cycle after every request, read or write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg.ack <= 1'b0;
			cfg.rdata <= 8'h00;
		end else begin
			cfg.ack <= cfg.req;
			if (cfg.req && !cfg.wr) begin
				cfg.rdata <= next_rdata;
			end
		end
	end

	// card side outputs, all registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ring_indicate_output <= 1'b0;
			speaker_output_pin <= 1'b0;
			speaker_output_pin_oe <= 1'b0;
			card_audio_pwm_output <= 1'b0;
			multipurpose_terminal <= 1'b0;
			power_down_grant <= 2'b00;
		end else begin
			ring_indicate_output <= ring_en && ring_s;
			// sockets merged by xor, each gated by its own enable
			speaker_output_pin <= (spk_s[0] && spk_en[0]) ^ (spk_s[1] && spk_en[1]);
			speaker_output_pin_oe <= |spk_en;
			// function 0 takes priority when both ask for the route
			if (audio_route[0]) begin
				card_audio_pwm_output <= aud_s[0];
			end else if (audio_route[1]) begin
				card_audio_pwm_output <= aud_s[1];
			end else begin
				card_audio_pwm_output <= 1'b0;
			end
			// terminal shows pwm only when configured with the audio code
			multipurpose_terminal <= (multipurpose_terminal_sel == CDCR_AUDIO_PWM_CODE) && (|audio_route) &&
				(audio_route[0] ? aud_s[0] : aud_s[1]);
			// a locked function in d3 refuses the power down
			power_down_grant <= power_down_req & ~(pwr_lock & d3_state);
		end
	end

	// register contents seen directly by the system
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_voltage_capable <= CDCR_DC_RESET[CDCR_DC_LV];
			interrupt_signal_mode <= cdcr_mode_t'(CDCR_DC_RESET[CDCR_DC_MODE_LO +: 2]);
			diagnostic_io_bit <= {2{CDCR_DC_RESET[CDCR_DC_DIAG]}};
			card_interrupt_flag <= 2'b00;
		end else begin
			low_voltage_capable <= lv_force;
			interrupt_signal_mode <= mode;
			diagnostic_io_bit <= diag;
			card_interrupt_flag <= iflag;
		end
	end
endmodule // cdcr_device

/* File: hw/cdcr_host.sv */
// host controller: apb orders turned into configuration accesses
module cdcr_host
	import cdcr_pkg::*;
(
	input wire logic pclk, // bus clock
	input wire logic presetn, // async low reset
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic irq, // level interrupt
	cdcr_cfg_if.host cfg // configuration access
);
	import cdcr_pkg::*;

	cdcr_hstate_t state; // sequencer
	logic c_wr; // latched direction
	logic c_func; // latched function
	logic [7:0] c_addr; // latched offset
	logic [7:0] c_data; // latched write byte
	logic [7:0] last_rdata; // last read answer
	logic istat; // done flag, write one clears
	logic imask; // done enable
	logic done_evt; // access finished this cycle
	logic apb_wr; // write taken at the ready edge only
	logic [7:0] merged; // write byte after software safety fixes
	logic [31:0] next_prdata; // read mux

	// the master holds the request until ready, so the write lands on that edge and no other
	assign apb_wr = psel && penable && pwrite && pready;
	assign done_evt = (state == CDCR_H_WAIT_ACC) && cfg.ack;

	// safety fixes on the written byte before it reaches the bank
	always_comb begin
		merged = c_data;
		if (c_addr == CDCR_CARD_CTRL_OFS) begin
			merged = (c_data & ~CDCR_CC_KEEP_MASK) | (cfg.rdata & CDCR_CC_KEEP_MASK);
		end else if (c_addr == CDCR_DEV_CTRL_OFS) begin
			merged = c_data & ~CDCR_DC_TEST_MASK;
		end else begin
			merged = c_data;
		end
	end

	// sequencer; card control writes read first to keep bits 6..3
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= CDCR_H_IDLE;
			c_wr <= 1'b0;
			c_func <= 1'b0;
			c_addr <= 8'h00;
			c_data <= 8'h00;
			last_rdata <= 8'h00;
			cfg.req <= 1'b0;
			cfg.func <= 1'b0;
			cfg.addr <= 8'h00;
			cfg.wr <= 1'b0;
			cfg.wdata <= 8'h00;
		end else begin
			cfg.req <= 1'b0;
			case (state)
				CDCR_H_IDLE: begin
					// a go while busy is dropped
					if (apb_wr && paddr == CDCR_APB_CMD && pwdata[CDCR_CMD_GO]) begin
						c_wr <= pwdata[CDCR_CMD_WR];
						c_func <= pwdata[CDCR_CMD_FUNC];
						c_addr <= pwdata[CDCR_CMD_ADDR_LO +: 8];
						c_data <= pwdata[CDCR_CMD_DATA_LO +: 8];
						state <= (pwdata[CDCR_CMD_WR] && pwdata[CDCR_CMD_ADDR_LO +: 8] == CDCR_CARD_CTRL_OFS) ?
							CDCR_H_RD_OLD : CDCR_H_ACCESS;
					end
				end
				CDCR_H_RD_OLD: begin
					cfg.req <= 1'b1;
					cfg.wr <= 1'b0;
					cfg.func <= c_func;
					cfg.addr <= c_addr;
					state <= CDCR_H_WAIT_OLD;
				end
				CDCR_H_WAIT_OLD: begin
					if (cfg.ack) begin
						// the interrupt flag must not be cleared by the merge
						c_data[CDCR_CC_IFLAG] <= c_data[CDCR_CC_IFLAG];
						state <= CDCR_H_ACCESS;
					end
				end
				CDCR_H_ACCESS: begin
					cfg.req <= 1'b1;
					cfg.wr <= c_wr;
					cfg.func <= c_func;
					cfg.addr <= c_addr;
					cfg.wdata <= merged;
					state <= CDCR_H_WAIT_ACC;
				end
				CDCR_H_WAIT_ACC: begin
					if (cfg.ack) begin
						if (!c_wr) begin
							last_rdata <= cfg.rdata;
						end
						state <= CDCR_H_IDLE;
					end
				end
				default: state <= CDCR_H_IDLE;
			endcase
		end
	end

	// done flag: the event wins over a clearing write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			istat <= 1'b0;
			imask <= 1'b0;
			irq <= 1'b0;
		end else begin
			if (done_evt) begin
				istat <= 1'b1;
			end else if (apb_wr && paddr == CDCR_APB_ISTAT && pwdata[0]) begin
				istat <= 1'b0;
			end
			if (apb_wr && paddr == CDCR_APB_IMASK) begin
				imask <= pwdata[0];
			end
			irq <= istat && imask;
		end
	end

	// apb read mux
	always_comb begin
		case (paddr)
			CDCR_APB_CMD: next_prdata = {8'h00, c_data, c_addr, 5'h00, c_func, c_wr, 1'b0};
			CDCR_APB_STAT: next_prdata = {16'h0000, last_rdata, 7'h00, state != CDCR_H_IDLE};
			CDCR_APB_ISTAT: next_prdata = {31'h0, istat};
			CDCR_APB_IMASK: next_prdata = {31'h0, imask};
			default: next_prdata = 32'h0000_0000;
		endcase
	end

	// one wait state so read data comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel && penable && !pready;
			if (psel && penable && !pready && !pwrite) begin
				prdata <= next_prdata;
			end
		end
	end
endmodule // cdcr_host

/* File: tb/cdcr_assertions.sv */
// concurrent checks on the configuration link between host and register bank
module cdcr_assertions
	import cdcr_pkg::*;
(
	input wire logic pclk, // bus clock
	input wire logic presetn, // async low reset
	input wire logic req, // access request
	input wire logic func, // target function
	input wire logic [7:0] addr, // byte offset
	input wire logic wr, // 1 write
	input wire logic [7:0] wdata, // write byte
	input wire logic ack, // answer pulse
	input wire logic [7:0] rdata // read byte
);
	// one domain only, so clock and reset are stated once
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic rd; // read request this cycle
	assign rd = req && !wr;
	logic unmapped; // offset outside the bank
	assign unmapped = (addr != CDCR_CARD_CTRL_OFS) && (addr != CDCR_DEV_CTRL_OFS);
	// each request is answered exactly one cycle later
	a_ack_one_cycle: assert property (req |=> ack)
		else $error("ack missing after request");
	// an answer never comes without a request
	a_no_stray_ack: assert property (!req |=> !ack)
		else $error("ack without request");
	a_dc_bit4_zero: assert property (rd && addr == CDCR_DEV_CTRL_OFS |=> !rdata[4])
		else $error("device control bit 4 read as one");
	a_cc_rsvd_zero: assert property (rd && addr == CDCR_CARD_CTRL_OFS |=> rdata[4:3] == 2'b00)
		else $error("card control bits 4:3 not zero");
	// unmapped offsets read back zero
	a_unmapped_zero: assert property (rd && unmapped |=> rdata == 8'h00)
		else $error("unmapped read not zero");
	// writes leave the last read byte in place, the host merge relies on it
	a_write_keeps_rdata: assert property (req && wr |=> $stable(rdata))
		else $error("rdata changed on a write");
	a_test_bit3_zero: assert property (req && wr && addr == CDCR_DEV_CTRL_OFS |-> !wdata[3])
		else $error("test bit 3 written as one");
	a_test_bit0_zero: assert property (req && wr && addr == CDCR_DEV_CTRL_OFS |-> !wdata[0])
		else $error("test bit 0 written as one");
	a_keep_merge: assert property (req && wr && addr == CDCR_CARD_CTRL_OFS |-> wdata[6:3] == rdata[6:3])
		else $error("card control bits 6:3 not preserved");
	// main traffic kinds
	c_card_read: cover property (rd && addr == CDCR_CARD_CTRL_OFS);
	c_fn1_write: cover property (req && wr && func);
	c_unmapped: cover property (rd && unmapped);
endmodule // cdcr_assertions

/* File: tb/card_device_control_regs_tb_top.sv */
// self-checking bench: apb orders through the host reach the register bank
module card_device_control_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import cdcr_pkg::*;
	`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin error_cnt++; \
		$display("ERROR %s expected %h seen %h", nm, ex, gt); end end
	localparam logic [7:0] CC = CDCR_CARD_CTRL_OFS; // short aliases
	localparam logic [7:0] DC = CDCR_DEV_CTRL_OFS;
	logic pclk = 1'b0; // 25 MHz clock
	logic presetn = 1'b0; // ordinary reset
	logic global_reset_n = 1'b0; // global reset
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb controls
	logic [11:0] paddr = 12'h000; // apb address
	logic [31:0] pwdata = 32'h0, prdata, r; // apb data
	logic pready, irq; // apb answer, interrupt
	logic ring_in = 1'b0; // ring pin
	logic [1:0] card_irq_in = 2'b00, card_speaker_input = 2'b00, card_audio_signal = 2'b00; // card pins
	logic [3:0] multipurpose_terminal_sel = 4'h0; // terminal configuration
	logic [1:0] d3_state = 2'b00, power_down_req = 2'b00; // power inputs
	logic ring_indicate_output, speaker_output_pin, speaker_output_pin_oe, card_audio_pwm_output; // pins
	logic multipurpose_terminal, low_voltage_capable; // terminal and capability
	logic [1:0] power_down_grant, diagnostic_io_bit, card_interrupt_flag; // per socket
	cdcr_mode_t interrupt_signal_mode; // signalling mode
	int error_cnt = 0, checks_done = 0, cyc = 0; // counters
	integer seed = 32'h00fe; // fixed seed
	logic [7:0] rb, v, f0; // read byte, random byte, fn0 device control
	cdcr_cfg_if cfg_bus();
	cdcr_device u_cdcr_device (.pclk(pclk), .presetn(presetn), .global_reset_n(global_reset_n), .cfg(cfg_bus),
		.ring_in(ring_in), .card_irq_in(card_irq_in), .card_speaker_input(card_speaker_input),
		.card_audio_signal(card_audio_signal), .multipurpose_terminal_sel(multipurpose_terminal_sel), .d3_state(d3_state),
		.power_down_req(power_down_req), .ring_indicate_output(ring_indicate_output),
		.speaker_output_pin(speaker_output_pin), .speaker_output_pin_oe(speaker_output_pin_oe),
		.card_audio_pwm_output(card_audio_pwm_output), .multipurpose_terminal(multipurpose_terminal),
		.power_down_grant(power_down_grant), .low_voltage_capable(low_voltage_capable),
		.interrupt_signal_mode(interrupt_signal_mode), .diagnostic_io_bit(diagnostic_io_bit),
		.card_interrupt_flag(card_interrupt_flag));
	cdcr_host u_cdcr_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .irq(irq), .cfg(cfg_bus));
	cdcr_assertions u_cdcr_assertions (.pclk(pclk), .presetn(presetn), .req(cfg_bus.req), .func(cfg_bus.func),
		.addr(cfg_bus.addr), .wr(cfg_bus.wr), .wdata(cfg_bus.wdata), .ack(cfg_bus.ack), .rdata(cfg_bus.rdata));
	// free running clock
	always #20 pclk = ~pclk;
	// hang guard, well above the few hundred cycles the run needs
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			end_sim();
		end
	end
	// shared bits from function 0, per-function bits from the reader
	function automatic logic [7:0] dc_exp(input logic [7:0] s, input logic [7:0] p);
		return (s & 8'h46) | (p & 8'ha0);
	endfunction
	// one apb transfer; waits for pready without assuming a latency
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// one configuration access through the host command word, then poll busy
	task automatic cfg(input logic w, input logic f, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		int n;
		apb(1'b1, CDCR_APB_CMD, {8'h00, d, a, 5'h00, f, w, 1'b1}, r);
		n = 0;
		do begin
			apb(1'b0, CDCR_APB_STAT, 32'h0, r);
			n++;
		end while (r[0] !== 1'b0 && n < 40);
		`CHK("cfg busy", 1'b0, r[0])
		q = r[15:8];
	endtask
	// reset pulse; the global reset joins only when asked
	task automatic rst(input logic g);
		presetn <= 1'b0;
		if (g) begin
			global_reset_n <= 1'b0;
		end
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		global_reset_n <= 1'b1;
		@(posedge pclk);
	endtask
	// verdict and end of run
	task automatic end_sim();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		@(posedge pclk);
		rst(1'b1);
		cfg(0, 0, CC, 0, rb); `CHK("cc reset", 8'h00, rb)
		cfg(0, 0, DC, 0, rb); `CHK("dc reset", CDCR_DC_RESET, rb)
		`CHK("lv reset", 1'b1, low_voltage_capable)
		`CHK("diag reset", 2'b11, diagnostic_io_bit)
		cfg(0, 0, 8'h93, 0, rb); `CHK("unmapped", 8'h00, rb)
		// every interrupt mode with random remaining bits, test bits included
		for (int m = 0; m < 4; m++) begin
			v = 8'($random(seed));
			v[2:1] = m[1:0];
			f0 = v;
			cfg(1, 0, DC, v, rb);
			cfg(0, 0, DC, 0, rb); `CHK("dc fn0", dc_exp(v, v), rb)
			`CHK("mode", m[1:0], interrupt_signal_mode)
			`CHK("lv", v[6], low_voltage_capable)
			`CHK("diag", v[5], diagnostic_io_bit[0])
		end
		// function 1 must not reach the shared copy
		v = 8'($random(seed));
		cfg(1, 1, DC, v, rb);
		cfg(0, 1, DC, 0, rb); `CHK("dc fn1", dc_exp(f0, v), rb)
		cfg(0, 0, DC, 0, rb); `CHK("dc fn0 kept", dc_exp(f0, f0), rb)
		// lock only on function 0, both sockets ask to power down in d3
		cfg(1, 0, DC, 8'h84, rb);
		cfg(1, 1, DC, 8'h00, rb);
		d3_state <= 2'b11;
		power_down_req <= 2'b11;
		repeat (3) @(posedge pclk);
		`CHK("grant d3", 2'b10, power_down_grant)
		d3_state <= 2'b00;
		repeat (3) @(posedge pclk);
		`CHK("grant d0", 2'b11, power_down_grant)
		rst(1'b0);
		cfg(0, 0, DC, 0, rb); `CHK("dc after presetn", 8'h84, rb)
		// routing with both functions enabled; fn1 ring enable must be ignored
		cfg(1, 0, CC, 8'h86, rb);
		cfg(1, 1, CC, 8'h06, rb);
		for (int i = 0; i < 8; i++) begin
			v = 8'($random(seed));
			card_speaker_input <= v[1:0];
			card_audio_signal <= v[3:2];
			ring_in <= v[4];
			multipurpose_terminal_sel <= v[5] ? CDCR_AUDIO_PWM_CODE : 4'h3;
			repeat (5) @(posedge pclk);
			`CHK("speaker", v[0] ^ v[1], speaker_output_pin)
			`CHK("spk oe", 1'b1, speaker_output_pin_oe)
			`CHK("pwm", v[2], card_audio_pwm_output)
			`CHK("terminal", v[5] & v[2], multipurpose_terminal)
			`CHK("ring", v[4], ring_indicate_output)
		end
		cfg(1, 0, CC, 8'h00, rb);
		// only function 1 still routes: its audio and its socket's speaker come through
		`CHK("pwm fn1", v[3], card_audio_pwm_output)
		`CHK("speaker fn1", v[1], speaker_output_pin)
		`CHK("spk oe fn1", 1'b1, speaker_output_pin_oe)
		cfg(1, 1, CC, 8'h00, rb);
		ring_in <= 1'b1;
		repeat (5) @(posedge pclk);
		`CHK("spk off", 1'b0, speaker_output_pin_oe)
		`CHK("ring off", 1'b0, ring_indicate_output)
		// socket 0 interrupt, then zero write, then one write
		card_irq_in <= 2'b01;
		repeat (5) @(posedge pclk);
		card_irq_in <= 2'b00;
		repeat (5) @(posedge pclk);
		`CHK("flag set", 2'b01, card_interrupt_flag)
		cfg(1, 0, CC, 8'h00, rb);
		cfg(0, 0, CC, 0, rb); `CHK("flag kept", 8'h01, rb)
		cfg(1, 0, CC, 8'h01, rb);
		cfg(0, 0, CC, 0, rb); `CHK("flag clear", 8'h00, rb)
		// socket 1 event held high across its clearing write: the set wins
		card_irq_in <= 2'b10;
		repeat (5) @(posedge pclk);
		cfg(1, 1, CC, 8'h01, rb);
		cfg(0, 1, CC, 0, rb); `CHK("flag held", 8'h01, rb)
		card_irq_in <= 2'b00;
		repeat (5) @(posedge pclk);
		cfg(1, 1, CC, 8'h01, rb);
		cfg(0, 1, CC, 0, rb); `CHK("flag1 clear", 8'h00, rb)
		// host interrupt: done is pending, unmask, clear, mask
		// irq is a flop behind the mask and status, so let one edge pass before looking
		apb(1'b1, CDCR_APB_IMASK, 32'h1, r);
		@(posedge pclk);
		`CHK("irq on", 1'b1, irq)
		apb(1'b1, CDCR_APB_ISTAT, 32'h1, r);
		@(posedge pclk);
		`CHK("irq clear", 1'b0, irq)
		apb(1'b1, CDCR_APB_IMASK, 32'h0, r);
		cfg(0, 0, CC, 0, rb); `CHK("irq masked", 1'b0, irq)
		apb(1'b0, 12'h010, 32'h0, r); `CHK("apb unmapped", 32'h0, r)
		rst(1'b1);
		cfg(0, 0, DC, 0, rb); `CHK("dc after global", CDCR_DC_RESET, rb)
		end_sim();
	end
endmodule // card_device_control_regs_tb_top
